//--- logic/port_e_pins_parallel_slave_ctrl.sv
/*
 * Pin control and parallel slave status for a three-pin port plus one
 * input-only pin shared with the external reset.
 * Assumes: pins and the configuration strap are asynchronous and are
 * synchronised here; the received host word and the data path live elsewhere.
 */
// Behaviour
// - Host write while a word is unread sets overrun; software clears it.
// - Slave select one gives parallel slave mode; zero gives plain I/O.
// - Direction bit one is input, zero output; bit 3 reads zero.
// - Output pins drive the latch bit regardless of analog selection.
// - Input pins read through readback, but read zero when analog.
// - In slave mode pin 0 input is the host read strobe.
// - In slave mode pins 1 and 2 are host write and select strobes.
// - After reset all three pins are analog channel inputs.
// - Pin 3 is the external reset input when its enable strap is set.
// - With the strap clear pin 3 reads as readback bit 3.
// - Pin 3 is input only and has no direction bit.
// - Latch register holds three bits; upper bits read zero.
`timescale 1ns/1ps

module port_e_pins_parallel_slave_ctrl
    import port_e_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic clk_en_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [DATA_W-1:0] rdata_out,
    input wire logic [NPINS-1:0] pin_in,
    input wire logic pin3_in,
    input wire logic external_reset_enable_cfg_in,
    output pin_drive_s pin_drive_out,
    output logic [NPINS-1:0] analog_channel_out,
    output logic slave_port_select_out,
    output logic host_read_strobe_out,
    output logic host_write_strobe_out,
    output logic external_reset_out,
    output logic irq_out
);

    // ************************************************************
    // Input synchronisers
    // ************************************************************

    // Synchroniser stages and the strobe history used for edge detection.
    logic [NPINS-1:0] pin_s1_q;
    logic [NPINS-1:0] pin_s2_q;
    logic pin3_s1_q;
    logic pin3_s2_q;
    logic cfg_s1_q;
    logic cfg_s2_q;
    logic wr_n_prev_q;
    logic rd_n_prev_q;

    // Two flops on every asynchronous input before any logic sees it.
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            pin_s1_q <= '1;
            pin_s2_q <= '1;
            pin3_s1_q <= 1'b1;
            pin3_s2_q <= 1'b1;
            cfg_s1_q <= 1'b0;
            cfg_s2_q <= 1'b0;
        end
        else if (clk_en_in)
        begin
            pin_s1_q <= pin_in;
            pin_s2_q <= pin_s1_q;
            pin3_s1_q <= pin3_in;
            pin3_s2_q <= pin3_s1_q;
            cfg_s1_q <= external_reset_enable_cfg_in;
            cfg_s2_q <= cfg_s1_q;
        end
    end

    // ************************************************************
    // Register state
    // ************************************************************

    // Software visible state, status flags and the registered read data.
    logic [NPINS-1:0] dir_q;
    logic [NPINS-1:0] latch_q;
    logic [NPINS-1:0] analog_q;
    logic slave_sel_q;
    logic in_waiting_q;
    logic out_pending_q;
    logic overrun_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_en_q;
    logic [DATA_W-1:0] rdata_q;

    // Zero padding above the narrow registers in the read view.
    localparam int unsigned PAD_W = DATA_W - NPINS;
    localparam int unsigned IRQ_PAD_W = DATA_W - IRQ_W;

    // Address decode.
    wire wr_dir = wr_in && (addr_in == REG_DIR_CTRL);
    wire wr_latch = wr_in && (addr_in == REG_LATCH);
    wire wr_analog = wr_in && (addr_in == REG_ANALOG_SEL);
    wire wr_out_word = wr_in && (addr_in == REG_OUT_WORD);
    wire wr_irq_en = wr_in && (addr_in == REG_IRQ_ENABLE);
    wire wr_irq_clr = wr_in && (addr_in == REG_IRQ_CLEAR);
    wire rd_in_word = rd_in && (addr_in == REG_IN_WORD);

    // Host strobes decode from synchronised pins, active low.
    host_strobe_s strobe;
    assign strobe.rd_n = pin_s2_q[0];
    assign strobe.wr_n = pin_s2_q[1];
    assign strobe.cs_n = pin_s2_q[2];
    wire slave_active = slave_sel_q;
    wire rd_as_strobe = slave_active && dir_q[0];
    wire wr_cs_strobe = slave_active && dir_q[1] && dir_q[2];
    wire host_wr_low = wr_cs_strobe && !strobe.wr_n && !strobe.cs_n;
    wire host_rd_low = rd_as_strobe && wr_cs_strobe && !strobe.rd_n && !strobe.cs_n;
    // A transfer completes on the rising edge of its strobe.
    wire host_wr_done = host_wr_low == 1'b0 && !wr_n_prev_q;
    wire host_rd_done = host_rd_low == 1'b0 && !rd_n_prev_q;
    wire overrun_evt = host_wr_done && in_waiting_q;

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            wr_n_prev_q <= 1'b1;
            rd_n_prev_q <= 1'b1;
        end
        else if (clk_en_in)
        begin
            wr_n_prev_q <= !host_wr_low;
            rd_n_prev_q <= !host_rd_low;
        end
    end

    // Configuration registers; reset leaves pins as analog inputs.
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            dir_q <= DIR_RESET;
            slave_sel_q <= 1'b0;
            latch_q <= LATCH_RESET;
            analog_q <= ANALOG_RESET;
            irq_en_q <= '0;
        end
        else if (clk_en_in)
        begin
            if (wr_dir)
            begin
                dir_q <= wdata_in[NPINS-1:0];
                slave_sel_q <= wdata_in[BIT_SLAVE_SEL];
            end
            if (wr_latch)
            begin
                latch_q <= wdata_in[NPINS-1:0];
            end
            if (wr_analog)
            begin
                analog_q <= wdata_in[NPINS-1:0];
            end
            if (wr_irq_en)
            begin
                irq_en_q <= wdata_in[IRQ_W-1:0];
            end
        end
    end

    // Status flags: a set in the same cycle as a clear wins.
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            in_waiting_q <= 1'b0;
            out_pending_q <= 1'b0;
            overrun_q <= 1'b0;
        end
        else if (clk_en_in)
        begin
            in_waiting_q <= host_wr_done || (in_waiting_q && !rd_in_word);
            out_pending_q <= wr_out_word || (out_pending_q && !host_rd_done);
            overrun_q <= overrun_evt || (overrun_q && !(wr_dir && !wdata_in[BIT_OVERRUN]));
        end
    end

    // Sticky interrupt status, cleared by writing ones to the clear register.
    // Event bits in status order: overrun, host read done, host write done.
    wire [IRQ_W-1:0] irq_evt = {overrun_evt, host_rd_done, host_wr_done};
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            irq_stat_q <= '0;
        end
        else if (clk_en_in)
        begin
            irq_stat_q <= irq_evt | (irq_stat_q & ~(wr_irq_clr ? wdata_in[IRQ_W-1:0] : '0));
        end
    end
    // The level interrupt stays high while any enabled sticky bit is set.
    assign irq_out = |(irq_stat_q & irq_en_q);

    // ************************************************************
    // Read path
    // ************************************************************

    // Read views of the registers, chosen by the index below.
    logic [DATA_W-1:0] dir_view;
    logic [DATA_W-1:0] readback_view;
    logic [DATA_W-1:0] rd_mux;
    assign dir_view = {in_waiting_q, out_pending_q, overrun_q, slave_sel_q, 1'b0, dir_q};
    // Digital input is disabled for analog pins; pin 3 only when strap clear.
    wire pin3_digital = pin3_s2_q && !cfg_s2_q;
    assign readback_view = {4'h0, pin3_digital, pin_s2_q & dir_q & ~analog_q};

    always_comb
    begin
        if (addr_in == REG_DIR_CTRL)
            rd_mux = dir_view;
        else if (addr_in == REG_LATCH)
            rd_mux = {{PAD_W{1'b0}}, latch_q};
        else if (addr_in == REG_READBACK)
            rd_mux = readback_view;
        else if (addr_in == REG_ANALOG_SEL)
            rd_mux = {{PAD_W{1'b0}}, analog_q};
        else if (addr_in == REG_IRQ_STATUS)
            rd_mux = {{IRQ_PAD_W{1'b0}}, irq_stat_q};
        else if (addr_in == REG_IRQ_ENABLE)
            rd_mux = {{IRQ_PAD_W{1'b0}}, irq_en_q};
        else
            rd_mux = 8'h00;
    end

    // Read data stands in the cycle after the strobe only.
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            rdata_q <= '0;
        else if (clk_en_in)
            rdata_q <= rd_in ? rd_mux : 8'h00;
    end
    assign rdata_out = rdata_q;

    // ************************************************************
    // Pin outputs
    // ************************************************************

    // Output pins drive the latch; output enable is low while driving.
    assign pin_drive_out.out = latch_q;
    assign pin_drive_out.oe_n = dir_q;
    assign analog_channel_out = analog_q & dir_q;
    assign slave_port_select_out = slave_sel_q;
    assign host_read_strobe_out = host_rd_low;
    assign host_write_strobe_out = host_wr_low;
    // Pin 3 is never driven; it resets the device only when enabled.
    assign external_reset_out = cfg_s2_q && !pin3_s2_q;

    // ************************************************************
    // Assertions
    // ************************************************************

    AST_FLAGS_READ: assert property (@(posedge clk_in) disable iff (!rstn_in)
        clk_en_in && rd_in && addr_in == REG_DIR_CTRL |=>
        rdata_out[BIT_IN_WAITING] == $past(in_waiting_q) &&
        rdata_out[BIT_OUT_PENDING] == $past(out_pending_q))
        else $error("status flags misreported");
    AST_OVERRUN_SET: assert property (@(posedge clk_in) disable iff (!rstn_in)
        clk_en_in && host_wr_done && in_waiting_q |=> overrun_q)
        else $error("overrun not set");
    AST_SLAVE_STROBE: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !slave_sel_q |-> !host_write_strobe_out && !host_read_strobe_out)
        else $error("strobe outside slave mode");
    AST_BIT3_ZERO: assert property (@(posedge clk_in) disable iff (!rstn_in)
        clk_en_in && rd_in && addr_in == REG_DIR_CTRL |=> !rdata_out[BIT_PIN3])
        else $error("bit 3 not zero");
    AST_DRIVE: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !dir_q[0] |-> !pin_drive_out.oe_n[0] && pin_drive_out.out[0] == latch_q[0])
        else $error("output pin not driven");
    AST_ANALOG_IN: assert property (@(posedge clk_in) disable iff (!rstn_in)
        clk_en_in && rd_in && addr_in == REG_READBACK && analog_q[1] |=> !rdata_out[1])
        else $error("analog pin read digital");
    AST_RX_CLEAR: assert property (@(posedge clk_in) disable iff (!rstn_in)
        clk_en_in && rd_in_word && !host_wr_done |=> !in_waiting_q)
        else $error("waiting flag not cleared");
    AST_TX_SET: assert property (@(posedge clk_in) disable iff (!rstn_in)
        clk_en_in && wr_out_word |=> out_pending_q ##0 $stable(latch_q))
        else $error("pending flag not set");
    AST_RESET_PIN: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !cfg_s2_q |-> !external_reset_out)
        else $error("reset pin active while disabled");

    // Status flags set on their events and hold until their own clear.
    AST_WAIT_SET: assert property (@(posedge clk_in) disable iff (!rstn_in)
        clk_en_in && host_wr_done |=> in_waiting_q)
        else $error("waiting flag not set");
    AST_WAIT_HOLD: assert property (@(posedge clk_in) disable iff (!rstn_in)
        in_waiting_q && !(clk_en_in && rd_in_word) |=> in_waiting_q)
        else $error("waiting flag lost");
    AST_TX_CLEAR: assert property (@(posedge clk_in) disable iff (!rstn_in)
        clk_en_in && host_rd_done && !wr_out_word |=> !out_pending_q)
        else $error("pending flag not cleared");
    AST_PEND_HOLD: assert property (@(posedge clk_in) disable iff (!rstn_in)
        out_pending_q && !(clk_en_in && host_rd_done) |=> out_pending_q)
        else $error("pending flag lost");
    AST_OVERRUN_HOLD: assert property (@(posedge clk_in) disable iff (!rstn_in)
        overrun_q && !(clk_en_in && wr_dir && !wdata_in[BIT_OVERRUN]) |=> overrun_q)
        else $error("overrun lost without clear");
    AST_IRQ_STICKY: assert property (@(posedge clk_in) disable iff (!rstn_in)
        irq_stat_q[IRQ_RX] && !(clk_en_in && wr_irq_clr && wdata_in[IRQ_RX]) |=> irq_stat_q[IRQ_RX])
        else $error("receive status bit lost");

    // Read views of the pins and the latch, and the enabled reset pin output.
    AST_PIN_READ: assert property (@(posedge clk_in) disable iff (!rstn_in)
        clk_en_in && rd_in && addr_in == REG_READBACK && dir_q[0] && !analog_q[0] |=> rdata_out[0] == $past(pin_s2_q[0]))
        else $error("digital input pin misread");
    AST_PIN3_READ: assert property (@(posedge clk_in) disable iff (!rstn_in)
        clk_en_in && rd_in && addr_in == REG_READBACK |=> rdata_out[BIT_PIN3] == $past(pin3_digital))
        else $error("input only pin misread");
    AST_LATCH_UPPER: assert property (@(posedge clk_in) disable iff (!rstn_in)
        clk_en_in && rd_in && addr_in == REG_LATCH |=> rdata_out[DATA_W-1:NPINS] == '0)
        else $error("latch upper bits not zero");
    AST_EXT_RESET_ON: assert property (@(posedge clk_in) disable iff (!rstn_in)
        cfg_s2_q && !pin3_s2_q |-> external_reset_out)
        else $error("enabled reset pin ignored");

    // Configuration writes reach the pins and the mode output.
    AST_DIR_WRITE: assert property (@(posedge clk_in) disable iff (!rstn_in)
        clk_en_in && wr_dir && !wdata_in[0] |=> !pin_drive_out.oe_n[0])
        else $error("pin not switched to output");
    AST_MODE_WRITE: assert property (@(posedge clk_in) disable iff (!rstn_in)
        clk_en_in && wr_dir && wdata_in[BIT_SLAVE_SEL] |=> slave_port_select_out)
        else $error("slave mode not entered");

    // Main scenarios: host write, host read, overrun, interrupt and reset pin.
    COV_EXT_RESET: cover property (@(posedge clk_in) disable iff (!rstn_in) external_reset_out);
    COV_HOST_WRITE: cover property (@(posedge clk_in) disable iff (!rstn_in) host_wr_done);
    COV_HOST_READ: cover property (@(posedge clk_in) disable iff (!rstn_in) host_rd_done);
    COV_OVERRUN: cover property (@(posedge clk_in) disable iff (!rstn_in) overrun_evt);
    COV_IRQ: cover property (@(posedge clk_in) disable iff (!rstn_in) irq_out);

endmodule

//--- logic/port_e_pkg.sv
/*
 * Package for the three-pin port with parallel slave strobes: register indices,
 * field positions, reset values and carrier structs.
 * Assumes a single 40 MHz clock domain and a plain strobe register port.
 */
package port_e_pkg;

    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned NPINS = 3;

    // Register indices.
    localparam logic [ADDR_W-1:0] REG_DIR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_LATCH = 4'h1;
    localparam logic [ADDR_W-1:0] REG_READBACK = 4'h2;
    localparam logic [ADDR_W-1:0] REG_ANALOG_SEL = 4'h3;
    localparam logic [ADDR_W-1:0] REG_IN_WORD = 4'h4;
    localparam logic [ADDR_W-1:0] REG_OUT_WORD = 4'h5;
    localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 4'h6;
    localparam logic [ADDR_W-1:0] REG_IRQ_ENABLE = 4'h7;
    localparam logic [ADDR_W-1:0] REG_IRQ_CLEAR = 4'h8;

    // Direction/status register fields.
    localparam int unsigned BIT_IN_WAITING = 7;
    localparam int unsigned BIT_OUT_PENDING = 6;
    localparam int unsigned BIT_OVERRUN = 5;
    localparam int unsigned BIT_SLAVE_SEL = 4;
    localparam int unsigned BIT_PIN3 = 3;

    // Reset values.
    localparam logic [NPINS-1:0] DIR_RESET = 3'h7;
    localparam logic [NPINS-1:0] ANALOG_RESET = 3'h7;
    localparam logic [NPINS-1:0] LATCH_RESET = 3'h0;

    // Interrupt event bits: write received, read done, overrun.
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_RX = 0;
    localparam int unsigned IRQ_TX = 1;
    localparam int unsigned IRQ_OVR = 2;

    typedef struct packed {
        logic [NPINS-1:0] out;
        logic [NPINS-1:0] oe_n;
    } pin_drive_s;

    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic cs_n;
    } host_strobe_s;

endpackage

//--- tb/host_strobe_model.sv
/*
 * Behavioural model of the external processor that drives the three port
 * pins as active-low read, write and select strobes, or plain levels.
 * Assumes the bench pulses one go input for one cycle and waits on busy.
 */
`timescale 1ns/1ps

module host_strobe_model
(
    input wire logic clk_in,
    input wire logic host_in,
    input wire logic go_wr_in,
    input wire logic go_rd_in,
    input wire logic [2:0] gpio_in,
    input wire logic [2:0] hold_in,
    output logic [2:0] pins_out,
    output logic busy_out
);
    logic [2:0] cnt_q = 3'h0;
    logic [2:0] drv_q = 3'h7;

    // Strobes are held for hold_in cycles, then released to the idle high level.
    always @(posedge clk_in)
    begin
        if (go_wr_in)
        begin
            drv_q <= 3'h1; // Write with select low
            cnt_q <= hold_in;
        end
        else if (go_rd_in)
        begin
            drv_q <= 3'h2; // Read with select low
            cnt_q <= hold_in;
        end
        else if (cnt_q != 3'h0)
        begin
            cnt_q <= cnt_q - 3'h1;
            if (cnt_q == 3'h1)
                drv_q <= 3'h7;
        end
    end

    // Outside host mode the pins carry the bench's plain levels.
    assign pins_out = host_in ? drv_q : gpio_in;
    assign busy_out = (cnt_q != 3'h0);
endmodule

//--- tb/test_port_e_pins_parallel_slave_ctrl.sv
/*
 * Self-checking bench for the port pin and slave status block.
 * Assumes the host model above drives the pins when slave mode is tested.
 */
`timescale 1ns/1ps

module test_port_e_pins_parallel_slave_ctrl import port_e_pkg::*;;
    logic clk_in = 0, rstn_in = 0, wr_in = 0, rd_in = 0, strap = 0, pin3 = 1;
    logic host = 0, go_wr = 0, go_rd = 0, seen, en = 1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h0, rdata, r, w;
    logic [2:0] gpio = 3'h0, hold = 3'h3, mpins, pins, ana;
    logic sel, hrs, hws, xrst, irq, busy;
    pin_drive_s drv;
    int error_cnt = 0, checked = 0, seed = 78, i, n;

    port_e_pins_parallel_slave_ctrl i_dut (.clk_in(clk_in), .rstn_in(rstn_in),
        .clk_en_in(en), .addr_in(addr), .wdata_in(wdata), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata), .pin_in(pins), .pin3_in(pin3), .external_reset_enable_cfg_in(strap),
        .pin_drive_out(drv), .analog_channel_out(ana), .slave_port_select_out(sel),
        .host_read_strobe_out(hrs), .host_write_strobe_out(hws),
        .external_reset_out(xrst), .irq_out(irq));
    host_strobe_model i_host (.clk_in(clk_in), .host_in(host), .go_wr_in(go_wr),
        .go_rd_in(go_rd), .gpio_in(gpio), .hold_in(hold), .pins_out(mpins), .busy_out(busy));

    // Wire level: the device wins where its enable is low.
    assign pins = (drv.oe_n & mpins) | (~drv.oe_n & drv.out);

    initial forever #12.5 clk_in = ~clk_in;

    task close_out;
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask

    // Read data is looked at in the single cycle after the strobe.
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_in);
        addr <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk(rdata, e);
    endtask

    // One host transfer, then time for the synchronisers and flags to settle.
    task host_op(input logic is_wr);
        seen = 1'b0;
        @(posedge clk_in);
        go_wr <= is_wr;
        go_rd <= ~is_wr;
        @(posedge clk_in);
        go_wr <= 1'b0;
        go_rd <= 1'b0;
        for (n = 0; n < 60 && (busy || n < 8); n++)
        begin
            #1 seen = seen | (is_wr ? hws : hrs);
            @(posedge clk_in);
        end
        if (busy)
        begin
            error_cnt++;
            close_out();
        end
        else
            chk({7'h0, seen}, 8'h01);
    endtask

    function automatic logic [7:0] exp_rb(logic [2:0] p, logic [2:0] d, logic [2:0] a,
                                          logic p3, logic s);
        return {4'h0, p3 & ~s, p & d & ~a};
    endfunction

    initial
    begin
        repeat (12) @(posedge clk_in);
        rstn_in <= 1'b1;
        #1 chk({5'h0, drv.oe_n}, 8'h07);
        chk({5'h0, ana}, 8'h07);
        rd(REG_DIR_CTRL, 8'h07);
        rd(REG_LATCH, 8'h00);
        rd(4'hf, 8'h00);
        $display("reset test done");
        for (i = 0; i < 12; i++)
        begin
            r = $random(seed);
            w = $random(seed);
            @(posedge clk_in);
            gpio <= w[6:4];
            pin3 <= w[7];
            strap <= r[7];
            wr(REG_DIR_CTRL, {4'h0, r[3:0]});
            wr(REG_LATCH, w);
            wr(REG_ANALOG_SEL, {5'h0, r[6:4]});
            rd(REG_DIR_CTRL, {5'h0, r[2:0]});
            rd(REG_LATCH, {5'h0, w[2:0]});
            chk({5'h0, drv.oe_n}, {5'h0, r[2:0]});
            chk({5'h0, drv.out}, {5'h0, w[2:0]});
            chk({5'h0, ana}, {5'h0, r[6:4] & r[2:0]});
            rd(REG_ANALOG_SEL, {5'h0, r[6:4]});
            rd(REG_READBACK, exp_rb(w[6:4], r[2:0], r[6:4], w[7], r[7]));
            chk({7'h0, xrst}, {7'h0, r[7] & ~w[7]});
        end
        $display("pin test done");
        @(posedge clk_in);
        host <= 1'b1;
        wr(REG_ANALOG_SEL, 8'h00);
        wr(REG_DIR_CTRL, 8'h1f);
        rd(REG_DIR_CTRL, 8'h17);
        chk({7'h0, sel}, 8'h01);
        wr(REG_IRQ_ENABLE, 8'h07);
        rd(REG_IRQ_ENABLE, 8'h07);
        host_op(1'b1);
        rd(REG_DIR_CTRL, 8'h97);
        rd(REG_IRQ_STATUS, 8'h01);
        chk({7'h0, irq}, 8'h01);
        @(posedge clk_in);
        hold <= 3'h6;
        host_op(1'b1);
        rd(REG_DIR_CTRL, 8'hb7);
        rd(REG_IN_WORD, 8'h00);
        rd(REG_DIR_CTRL, 8'h37);
        wr(REG_DIR_CTRL, 8'h17);
        rd(REG_DIR_CTRL, 8'h17);
        wr(REG_OUT_WORD, 8'h5a);
        rd(REG_DIR_CTRL, 8'h57);
        host_op(1'b0);
        rd(REG_DIR_CTRL, 8'h17);
        rd(REG_IRQ_STATUS, 8'h07);
        wr(REG_IRQ_ENABLE, 8'h00);
        @(posedge clk_in);
        #1 chk({7'h0, irq}, 8'h00);
        wr(REG_IRQ_ENABLE, 8'h07);
        wr(REG_IRQ_CLEAR, 8'h07);
        rd(REG_IRQ_STATUS, 8'h00);
        chk({7'h0, irq}, 8'h00);
        $display("slave test done");
        // A write while the clock enable is low must leave the latch untouched.
        @(posedge clk_in);
        en <= 1'b0;
        wr(REG_LATCH, ~w);
        en <= 1'b1;
        rd(REG_LATCH, {5'h0, w[2:0]});
        $display("freeze test done");
        close_out();
    end
endmodule
